/* File: tb/nfh_flash_model.sv */
// Behavioural flash: latches, read port, ready/busy
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int          BUSY_CYC = 40,       // Busy span, kept short
  parameter logic [15:0] RD_BASE  = 16'hC300  // Read word pattern
)(
  input  wire logic            clk_i,   // Bench clock
  input  wire nfh_pins_t       pins_i,  // Host pins
  input  wire logic [IO_W-1:0] io_i,    // Host port value
  input  wire logic            oe_i,    // Host drives port
  output logic [IO_W-1:0]      io_o,    // Resolved port level
  output logic                 rb_n_o,  // Ready/busy, pulled up
  output logic [IO_W-1:0]      cmd_o,   // Last command seen
  output logic [IO_W-1:0]      adr_o,   // Last address seen
  output logic [IO_W-1:0]      dat_o    // Last data seen
);
  int              busy_n = 0;        // Busy cycles left
  logic            go = 0, go_q = 0;  // Start toggle, its copy
  logic            drv = 0;           // Read word on port
  logic [IO_W-1:0] word, col = '0;    // Out word, column
  logic [IO_W-1:0] flt = 16'h1234;    // Float junk, never settles
  // Host wins, then read word, else junk so stale data never matches
  assign io_o   = oe_i ? io_i : (drv && !pins_i.sel_n) ? word : flt;
  assign rb_n_o = (busy_n == 0);
  // Capture on write rise, by latch kind
  always @(posedge pins_i.wr_strobe_n) if (!pins_i.sel_n) begin
    if (pins_i.cmd_latch) begin
      cmd_o = io_o;
      if (io_o[7:0] inside {8'h10, 8'hD0} && pins_i.wprot_n) go = ~go;
    end else if (pins_i.addr_latch) begin
      adr_o = io_o;
      col   = {8'h00, io_o[7:0]};
    end else dat_o = io_o;
  end
  // Read fall: next word, column steps by one
  always @(negedge pins_i.read_strobe_n) if (!pins_i.sel_n) begin
    word = RD_BASE ^ col;
    col  = col + 16'h0001;
    drv  = 1'b1;
  end
  // Short output hold after the strobe rises
  always @(posedge pins_i.read_strobe_n) begin
    #50;
    drv = 1'b0;
  end
  // Sequencer runs alone; select is not looked at while busy
  always @(posedge clk_i) begin
    flt  <= {flt[14:0], ~flt[15]};
    go_q <= go;
    if (go != go_q) busy_n <= BUSY_CYC;
    else if (busy_n > 0) busy_n <= busy_n - 1;
  end
endmodule // nfh_flash_model

/* File: tb/tb_top.sv */
// Bench: host controller against the behavioural flash
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nfh_pkg::*;
  localparam logic [15:0] RD_BASE = 16'hC300; // Read pattern
  logic ref_clk_i = 0, rstn_i = 0, ce_i = 1, req_valid_i = 0, rsp_ready_i = 0;
  logic wprot_i = 1, deselect_i = 0, req_ready_o, rsp_valid_o, busy_o, io_port_oe_o, rb_n;
  nfh_req_t        req_i = '0, rsp_o;              // Request, answer
  nfh_pins_t       pins_o;                         // Flash pins
  logic [IO_W-1:0] io_port_o, io_lvl, m_cmd, m_adr, m_dat, col;
  logic [16:0]     expq[$], e;                     // Notes {care, word}
  logic [1:0]      mode = 0;                       // Ready: stall, on, random
  logic [31:0]     r;                              // Random draw
  int fails = 0, n_checks = 0, seed = 32'h2447;
  nfh_host u_nfh_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .wprot_i(wprot_i),
    .deselect_i(deselect_i), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
    .rsp_ready_i(rsp_ready_i), .busy_o(busy_o), .pins_o(pins_o), .io_port_i(io_lvl),
    .io_port_o(io_port_o), .io_port_oe_o(io_port_oe_o), .ready_busy_n_i(rb_n));
  nfh_flash_model u_nfh_flash_model (.clk_i(ref_clk_i), .pins_i(pins_o), .io_i(io_port_o),
    .oe_i(io_port_oe_o), .io_o(io_lvl), .rb_n_o(rb_n), .cmd_o(m_cmd), .adr_o(m_adr),
    .dat_o(m_dat));
  // Clock, 25 ns
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Offer one request; optionally prove a full buffer refuses it first
  task automatic send(input nfh_op_t op, input logic [15:0] d, input bit full = 0);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req_i       = '{op: op, data: d};
    req_valid_i = 1'b1;
    if (full) begin
      repeat (8) @(negedge ref_clk_i);
      chk({15'h0, req_ready_o}, 16'h0000);
      mode = 2'd1;
    end
    #1;
    while (req_ready_o !== 1'b1 && n < 500) begin
      @(negedge ref_clk_i);
      #1 n++;
    end
    if (n >= 500) fails++;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic care, input bit full = 0);
    expq.push_back({care, RD_BASE ^ col});
    col = col + 16'h0001;
    send(NFH_OP_RD, 16'h0000, full);
  endtask
  // Bounded waits on flash busy and on the note queue
  task automatic wait_on(input logic v, input bit q);
    int n;
    n = 0;
    while ((q ? expq.size() > 0 : busy_o !== v) && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 400) fails++;
  endtask
  // Receiver ready: stalled, steady or random
  always @(negedge ref_clk_i) rsp_ready_i <= (mode == 2'd2) ? 1'($random(seed)) : mode[0];
  // Result side: oldest note against each word taken
  always @(posedge ref_clk_i) if (rstn_i && rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
    e = (expq.size() > 0) ? expq.pop_front() : 17'h1DEAD;
    if (e[16]) chk(rsp_o.data, e[15:0]);
    chk({14'h0, rsp_o.op}, 16'h0003);
  end
  initial begin
    #500000;
    fails++;
    test_done;
  end
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rstn_i = 1;
    wait_on(1'b0, 0);
    mode = 2'd1;
    // Random bytes; upper half of cmd and address must not reach the flash
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      if (r[7:0] inside {8'h10, 8'hD0}) r[0] = ~r[0];
      send(NFH_OP_CMD, r[15:0]);
      chk(m_cmd, {8'h00, r[7:0]});
      send(NFH_OP_ADDR, r[31:16]);
      chk(m_adr, {8'h00, r[23:16]});
      send(NFH_OP_WR, r[15:0] ^ r[31:16]);
      chk(m_dat, r[15:0] ^ r[31:16]);
    end
    // Identification: four words, third not compared, no fifth
    mode = 2'd2;
    send(NFH_OP_CMD, 16'h0090);
    send(NFH_OP_ADDR, 16'h0000);
    col = '0;
    for (int i = 0; i < 4; i++) rd(i != 2);
    wait_on(1'b0, 1);
    // Receiver stalls: two words fill the buffer, third waits
    mode = 2'd0;
    rd(1'b1);
    rd(1'b1);
    rd(1'b1, 1);
    wait_on(1'b0, 1);
    // Program: busy, and deselect ignored until ready
    send(NFH_OP_CMD, 16'h0010);
    wait_on(1'b1, 0);
    chk({15'h0, busy_o}, 16'h0001);
    deselect_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk({15'h0, pins_o.sel_n}, 16'h0000);
    wait_on(1'b0, 0);
    repeat (4) @(negedge ref_clk_i);
    chk({15'h0, pins_o.sel_n}, 16'h0001);
    deselect_i = 1'b0;
    // Erase protected: no busy; then unprotected: busy
    wprot_i = 1'b0;
    send(NFH_OP_CMD, 16'h00D0);
    chk({15'h0, pins_o.wprot_n}, 16'h0000);
    repeat (8) @(negedge ref_clk_i);
    chk({15'h0, busy_o}, 16'h0000);
    wprot_i = 1'b1;
    send(NFH_OP_CMD, 16'h00D0);
    wait_on(1'b1, 0);
    chk({15'h0, busy_o}, 16'h0001);
    wait_on(1'b0, 0);
    test_done;
  end
endmodule // tb_top

/* File: verilog/nfh_host.sv */
// Host controller that drives a NAND flash through its pins
// Rules of the flash that this block works with
// (R1) Command taken at write rise, latch high
// (R2) Address taken at write rise, latch high
// (R3) Select ignored while flash busy
// (R4) Each read fall gives next word
// (R5) Flash drives port only during read
// (R6) Port floats when deselected or disabled
// (R7) Commands and addresses on low byte only
// (R8) Third identification byte is undefined
// (R9) No fifth identification byte exists
// (R10) Program works on a whole page
// (R11) Erase works on a whole block
// (R12) Flash runs program and erase itself
// (R13) All bytes captured at write rise
// (R14) Ready/busy low while operation runs
// (R15) Write protect low blocks program, erase
// (R16) Never both latches; wait ready first
module nfh_host
  import nfh_pkg::*;
(
  input  wire logic            ref_clk_i,     // 40 MHz clock
  input  wire logic            rstn_i,        // Synchronous reset, active low
  input  wire logic            ce_i,          // Clock enable
  input  wire nfh_req_t        req_i,         // Request word
  input  wire logic            req_valid_i,   // Request offered
  output logic                 req_ready_o,   // Request accepted
  input  wire logic            wprot_i,       // Allow program and erase
  input  wire logic            deselect_i,    // Ask to deselect the flash
  output nfh_req_t             rsp_o,         // Read word, op field reads as read
  output logic                 rsp_valid_o,   // Read word valid
  input  wire logic            rsp_ready_i,   // User takes read word
  output logic                 busy_o,        // Flash busy, synchronised
  output nfh_pins_t            pins_o,        // Control pins to flash
  input  wire logic [IO_W-1:0] io_port_i,     // Port level seen
  output logic [IO_W-1:0]      io_port_o,     // Port value driven
  output logic                 io_port_oe_o,  // High while we drive the port
  input  wire logic            ready_busy_n_i // Ready/busy pin, low while busy
);

  // Sequencer states, Gray coded along strobe-low, strobe-high, wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11,
    ST_WAIT = 2'b10
  } nfh_st_t;

  nfh_st_t          st_q, st_d;          // Sequencer state
  nfh_req_t         cur_q;               // Request in progress
  logic [3:0]       tim_q;               // Phase timer
  logic [1:0]       rb_q;                // Ready/busy synchroniser
  logic [IO_W-1:0]  io_s1_q, io_s2_q;    // Port synchroniser
  logic             sel_n_q;             // Select pin register
  nfh_req_t         buf_q [2];           // Two-entry read buffer
  logic             wp_q, rp_q;          // Buffer pointers
  logic [1:0]       cnt_q;               // Buffer fill level

  // Truncates a phase figure to a four-bit timer value
  function automatic logic [3:0] phase_len(input int unsigned cyc);
    return 4'(cyc);
  endfunction

  // Busy view from the second synchroniser stage only
  wire        flash_busy = ~rb_q[1];                                   // R14
  wire        is_rd      = (cur_q.op == NFH_OP_RD);
  wire        buf_full   = (cnt_q == 2'h2);
  // A read waits for room so that a stalled receiver loses no word
  wire        can_start  = (st_q == ST_IDLE) && !flash_busy && req_valid_i
                           && !(req_i.op == NFH_OP_RD && buf_full);      // R16
  wire        tim_done   = (tim_q == TIM_RST);
  // Port taken in the wait phase: the synchroniser then holds the level seen
  // while the read strobe was low, not the stale level from before its fall
  wire        push       = ce_i && st_q == ST_WAIT && is_rd;
  wire        pop        = ce_i && rsp_valid_o && rsp_ready_i;

  assign req_ready_o = can_start;
  assign busy_o      = flash_busy;
  assign rsp_valid_o = (cnt_q != 2'h0);
  // Words pass on untouched; judging identification words is left to the user
  assign rsp_o       = buf_q[rp_q];                                      // R8 R9

  // Next state of the strobe sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (can_start) st_d = ST_LOW;
      ST_LOW:  if (tim_done) st_d = ST_HIGH;
      ST_HIGH: if (tim_done) st_d = ST_WAIT;
      ST_WAIT: st_d = ST_IDLE;
    endcase
  end

  // Sequencer, timer and request register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st_q  <= ST_IDLE;
      tim_q <= TIM_RST;
      cur_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      if (can_start) begin
        cur_q <= req_i;
        // Strobe low phase: write pulse or read pulse
        tim_q <= phase_len((req_i.op == NFH_OP_RD) ? RP_CYC : WP_CYC) - 4'h1;
      end else if (st_q == ST_LOW && tim_done) begin
        tim_q <= phase_len(is_rd ? REH_CYC : WH_CYC) - 4'h1;
      end else if (!tim_done) begin
        tim_q <= tim_q - 4'h1;
      end
    end
  end

  // Select: deselect only once the flash is ready again
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sel_n_q <= 1'b1;
    end else if (ce_i) begin
      if (can_start) begin
        sel_n_q <= 1'b0;
      end else if (deselect_i && st_q == ST_IDLE && !flash_busy) begin
        sel_n_q <= 1'b1;                                                 // R3
      end
    end
  end

  // Synchronisers for the pins coming back from the flash
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rb_q    <= 2'h0;
      io_s1_q <= '0;
      io_s2_q <= '0;
    end else if (ce_i) begin
      rb_q    <= {rb_q[0], ready_busy_n_i};
      io_s1_q <= io_port_i;
      io_s2_q <= io_s1_q;
    end
  end

  // Pin drive: one latch at a time, low byte for command and address
  assign pins_o.cmd_latch     = (st_q != ST_IDLE) && cur_q.op == NFH_OP_CMD;  // R1
  assign pins_o.addr_latch    = (st_q != ST_IDLE) && cur_q.op == NFH_OP_ADDR; // R2
  assign pins_o.sel_n         = sel_n_q;
  // Rising edge of the write strobe at the end of the low phase
  assign pins_o.wr_strobe_n   = !(st_q == ST_LOW && !is_rd);                  // R13
  // Every read fall moves the flash column counter on by one
  assign pins_o.read_strobe_n = !(st_q == ST_LOW && is_rd);                   // R4
  // Program and erase blocked by the flash while protection is held
  assign pins_o.wprot_n       = wprot_i;                                      // R15
  // We never drive during a read, so the flash owns the port there
  assign io_port_oe_o         = (st_q != ST_IDLE) && !is_rd;                  // R5
  assign io_port_o            = (cur_q.op == NFH_OP_CMD || cur_q.op == NFH_OP_ADDR)
                                ? {8'h00, cur_q.data[CMD_W-1:0]} : cur_q.data; // R7

  // Read buffer; data sampled after the two synchroniser stages
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= '{op: NFH_OP_RD, data: io_s2_q};                 // R5
        wp_q        <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Protocol checks on the pins we drive and on the read buffer
  AST_ONE_LATCH: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
    !(pins_o.cmd_latch && pins_o.addr_latch))
    else $error("Both latch strobes high");
  AST_CMD_RISE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R1
    $rose(pins_o.wr_strobe_n) && cur_q.op == NFH_OP_CMD |-> pins_o.cmd_latch)
    else $error("Command write rise without latch");
  AST_ADDR_RISE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R2
    $rose(pins_o.wr_strobe_n) && cur_q.op == NFH_OP_ADDR |-> pins_o.addr_latch)
    else $error("Address write rise without latch");
  AST_NO_DRIVE_RD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R5
    !pins_o.read_strobe_n |-> !io_port_oe_o)
    else $error("Port driven during read");
  AST_LOW_BYTE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R7
    (pins_o.cmd_latch || pins_o.addr_latch) |-> io_port_o[IO_W-1:CMD_W] == 8'h00)
    else $error("Upper byte set on command or address");
  AST_BUSY_WAIT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
    flash_busy |-> !req_ready_o)
    else $error("Request taken while busy");
  AST_SEL_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R3
    flash_busy && !sel_n_q |=> !pins_o.sel_n)
    else $error("Deselected while busy");
  // A read pulse that runs on unfrozen must end in exactly one buffered word
  AST_RD_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R4
    ce_i && $fell(pins_o.read_strobe_n) ##1 ce_i
    |-> $rose(pins_o.read_strobe_n) ##1 (push || !ce_i))
    else $error("Read pulse did not yield one word");
  // A waiting word must neither vanish nor change under a stalled receiver
  AST_RSP_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R4
    rsp_valid_o && !(rsp_ready_i && ce_i) |=> rsp_valid_o && $stable(rsp_o))
    else $error("Read word lost while stalled");
  // Only one read is ever in flight and none starts on a full buffer, so the fill level stops at two
  AST_BUF_LIMIT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R4
    cnt_q != 2'h3)
    else $error("Read buffer overfilled");
  // Deselected flash floats its port, so we must not be driving it either
  AST_OE_SEL: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R6
    pins_o.sel_n |-> !io_port_oe_o)
    else $error("Port driven while deselected");
  // Write and read strobes never overlap
  AST_ONE_STROBE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    !(!pins_o.wr_strobe_n && !pins_o.read_strobe_n))
    else $error("Write and read strobes low together");
  // Each write pulse rises after its single low phase
  AST_WR_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    ce_i && !pins_o.wr_strobe_n |=> pins_o.wr_strobe_n)
    else $error("Write strobe held low too long");
  // A read cycle never raises a latch strobe
  AST_NO_LATCH_RD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
    !pins_o.read_strobe_n |-> !(pins_o.cmd_latch || pins_o.addr_latch))
    else $error("Latch strobe high during read");
  // Latches only rise toward a selected flash
  AST_LATCH_SEL: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R1
    (pins_o.cmd_latch || pins_o.addr_latch) |-> !pins_o.sel_n)
    else $error("Latch strobe high while deselected");

endmodule : nfh_host

/* File: verilog/nfh_pkg.sv */
// Package: constants and carrier types for the NAND pin host controller
package nfh_pkg;

  // Width of the I/O port; sixteen-bit variant, commands use low byte only
  localparam int unsigned IO_W        = 16;
  localparam int unsigned CMD_W       = 8;

  // Clock rate and pin timing in ns, turned into cycles (least times round up)
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned T_WP_NS     = 25;
  localparam int unsigned T_WH_NS     = 15;
  localparam int unsigned T_RP_NS     = 25;
  localparam int unsigned T_REH_NS    = 15;
  localparam int unsigned WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WH_CYC      = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REH_CYC     = (T_REH_NS + CLK_NS - 1) / CLK_NS;

  // Page sizes: 2112 bytes or 1056 words
  localparam int unsigned PAGE_BYTES  = 2112;
  localparam int unsigned PAGE_WORDS  = 1056;

  // Counter width, and the phase timer reset value
  localparam int unsigned CNT_W       = 12;
  localparam logic [3:0]  TIM_RST     = 4'h0;

  // Kinds of bus cycle a request may ask for
  typedef enum logic [1:0] {
    NFH_OP_CMD  = 2'h0,
    NFH_OP_ADDR = 2'h1,
    NFH_OP_WR   = 2'h2,
    NFH_OP_RD   = 2'h3
  } nfh_op_t;

  // One request from the user side
  typedef struct packed {
    nfh_op_t           op;
    logic [IO_W-1:0]   data;
  } nfh_req_t;

  // Pin outputs toward the flash
  typedef struct packed {
    logic              cmd_latch;
    logic              addr_latch;
    logic              sel_n;
    logic              wr_strobe_n;
    logic              read_strobe_n;
    logic              wprot_n;
  } nfh_pins_t;

endpackage : nfh_pkg
